// ==== core/clid_top.sv ====
// Instruction decoder of a character display controller behind an AHB-Lite slave
`timescale 1ns/100ps
module clid_top #(
   parameter int ADDR_W = 8,
   parameter int CLEAR_CYC = clid_pkg::CLEAR_CYC_DEF,
   parameter int BLINK_CYC = clid_pkg::BLINK_CYC_DEF,
   parameter int DD_DEPTH = 128,
   parameter int CG_DEPTH = 64
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output clid_pkg::clid_panel_type panel
);
   import clid_pkg::*;

   localparam int DD_AW = $clog2(DD_DEPTH);
   localparam int CG_AW = $clog2(CG_DEPTH);

   // Clear must outlast the one-cell-per-cycle fill of the text RAM
   if (ADDR_W < 8 || DD_DEPTH != 128 || CG_DEPTH != 64 || CLEAR_CYC <= DD_DEPTH
         || CLEAR_CYC >= 2 ** BUSY_W || BLINK_CYC < 2 || BLINK_CYC >= 2 ** BLINK_W) begin : g_bad
      $error("clid_top: parameter values not supported");
   end

   function automatic logic [6:0] clid_step(input logic [6:0] a, input logic up,
                                            input logic cg);
      logic [6:0] n;
      n = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
      // Pattern RAM addresses wrap inside six bits
      return cg ? {1'b0, n[5:0]} : n;
   endfunction

   clid_mode_type mode_r;
   logic [BUSY_W-1:0] busy_cnt_r;
   logic [6:0] addr_counter_r;
   logic [6:0] shift_off_r;
   logic pend_step_r;
   logic pend_shift_r;
   logic pend_rd_r;
   logic refresh_r;
   logic [7:0] latch_r;
   logic fill_act_r;
   logic [DD_AW-1:0] fill_cnt_r;
   logic nib_phase_r;
   logic [3:0] nib_buf_r;
   logic wr_ph_r;
   logic [7:0] wofs_r;
   logic [BLINK_W-1:0] blink_cnt_r;
   logic blink_ph_r;
   logic [7:0] dd_mem [DD_DEPTH];
   logic [7:0] cg_mem [CG_DEPTH];

   logic busy_bit;
   logic busy_end;
   logic acc;
   logic [7:0] ofs;
   logic cmd_wr;
   logic data_wr;
   logic cmd_rd;
   logic data_rd;
   logic wdone;
   logic [7:0] byte_w;
   logic cmd_go;
   logic dwr_go;
   logic drd_go;
   logic is_clear;
   logic is_home;
   logic is_entry;
   logic is_dctl;
   logic is_shift;
   logic is_func;
   logic is_cgset;
   logic is_ddset;
   logic [7:0] rd_raw;
   logic [7:0] rd_byte;

   assign busy_bit = busy_cnt_r != '0;
   assign busy_end = busy_cnt_r == BUSY_W'(1);
   assign ofs = haddr[7:0];
   assign acc = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
   assign cmd_wr = wr_ph_r & (wofs_r == OFS_CMD);
   assign data_wr = wr_ph_r & (wofs_r == OFS_DATA);
   assign cmd_rd = acc & ~hwrite & (ofs == OFS_CMD);
   assign data_rd = acc & ~hwrite & (ofs == OFS_DATA);
   // Narrow bus: the second access completes the byte, high nibble came first
   assign wdone = mode_r.bus_width | nib_phase_r;
   assign byte_w = mode_r.bus_width ? hwdata[7:0] : {nib_buf_r, hwdata[7:4]};
   // Accesses while busy are dropped; the host is expected to poll first
   assign cmd_go = cmd_wr & wdone & ~busy_bit & (byte_w != 8'h00);
   assign dwr_go = data_wr & wdone & ~busy_bit;
   assign drd_go = data_rd & wdone & ~busy_bit;
   // Decode by the highest set bit, lower bits are don't care
   assign is_clear = byte_w == CLEAR_CODE;
   assign is_home = byte_w[7:1] == 7'h01;
   assign is_entry = byte_w[7:2] == 6'h01;
   assign is_dctl = byte_w[7:3] == 5'h01;
   assign is_shift = byte_w[7:4] == 4'h1;
   assign is_func = byte_w[7:5] == 3'h1;
   assign is_cgset = byte_w[7:6] == 2'h1;
   assign is_ddset = byte_w[7];

   // Bus slave: zero wait states, write data taken in the data phase
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ph_r <= 1'b0;
         wofs_r <= 8'h00;
      end else begin
         wr_ph_r <= acc & hwrite;
         wofs_r <= ofs;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Narrow bus shows the high nibble first, then the low one, both on bits 7..4
   assign rd_raw = (ofs == OFS_CMD) ? {busy_bit, addr_counter_r} : latch_r;
   assign rd_byte = mode_r.bus_width ? rd_raw
                                     : {(nib_phase_r ? rd_raw[3:0] : rd_raw[7:4]), 4'h0};

   // Read data is prepared at the address phase so it stands in the data phase
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (acc & ~hwrite) begin
         if (ofs == OFS_CMD || ofs == OFS_DATA) begin
            hrdata <= {24'h00_0000, rd_byte};
         end else if (ofs == OFS_MODE) begin
            hrdata <= {16'h0000, shift_off_r, mode_r};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // Nibble pairing for the narrow bus
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         nib_phase_r <= 1'b0;
         nib_buf_r <= 4'h0;
      end else if (mode_r.bus_width) begin
         nib_phase_r <= 1'b0;
      end else if (cmd_wr | data_wr) begin
         nib_phase_r <= ~nib_phase_r;
         if (!nib_phase_r) begin
            nib_buf_r <= hwdata[7:4];
         end
      end else if (cmd_rd | data_rd) begin
         nib_phase_r <= ~nib_phase_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         busy_cnt_r <= '0;
      end else if (cmd_go) begin
         if (is_clear | is_home) begin
            busy_cnt_r <= BUSY_W'(CLEAR_CYC);
         end else begin
            busy_cnt_r <= BUSY_W'(CMD_CYC);
         end
      end else if (dwr_go | drd_go) begin
         busy_cnt_r <= BUSY_W'(DATA_CYC);
      end else if (busy_bit) begin
         busy_cnt_r <= busy_cnt_r - BUSY_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode_r <= '{RST_ENTRY_INC, RST_SHIFT_EN, RST_DISP_ON, RST_CURSOR_ON, RST_BLINK_ON,
                     RST_BUS_WIDTH, RST_TWO_LINE, RST_FONT_BIG, RST_CG_SEL};
      end else if (cmd_go) begin
         if (is_clear) begin
            mode_r.entry_inc <= 1'b1;
            mode_r.cg_sel <= 1'b0;
         end else if (is_home) begin
            mode_r.cg_sel <= 1'b0;
         end else if (is_entry) begin
            mode_r.entry_inc <= byte_w[B_INC];
            mode_r.shift_en <= byte_w[B_AUTO_SHIFT];
         end else if (is_dctl) begin
            mode_r.disp_on <= byte_w[B_DISP];
            mode_r.cursor_on <= byte_w[B_CUR];
            mode_r.blink_on <= byte_w[B_BLINK];
         end else if (is_func) begin
            mode_r.bus_width <= byte_w[B_BUS_WIDTH];
            mode_r.two_line <= byte_w[B_TWO_LINE];
            mode_r.font_big <= byte_w[B_FONT_BIG];
         end else if (is_cgset) begin
            mode_r.cg_sel <= 1'b1;
         end else if (is_ddset) begin
            mode_r.cg_sel <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         addr_counter_r <= 7'h00;
      end else if (cmd_go) begin
         if (is_clear | is_home) begin
            addr_counter_r <= 7'h00;
         end else if (is_shift && !byte_w[B_SHIFT_DISP]) begin
            addr_counter_r <= clid_step(addr_counter_r, byte_w[B_SHIFT_RIGHT],
                                        mode_r.cg_sel);
         end else if (is_cgset) begin
            addr_counter_r <= {1'b0, byte_w[5:0]};
         end else if (is_ddset) begin
            addr_counter_r <= byte_w[6:0];
         end
      end else if (pend_step_r && busy_end) begin
         addr_counter_r <= clid_step(addr_counter_r, mode_r.entry_inc, mode_r.cg_sel);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         shift_off_r <= 7'h00;
      end else if (cmd_go && (is_clear || is_home)) begin
         shift_off_r <= 7'h00;
      end else if (cmd_go && is_shift && byte_w[B_SHIFT_DISP]) begin
         // Left shift advances the window start
         shift_off_r <= byte_w[B_SHIFT_RIGHT] ? 7'(shift_off_r - 7'h01)
                                              : 7'(shift_off_r + 7'h01);
      end else if (pend_shift_r && busy_end) begin
         shift_off_r <= mode_r.entry_inc ? 7'(shift_off_r + 7'h01)
                                         : 7'(shift_off_r - 7'h01);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pend_step_r <= 1'b0;
         pend_shift_r <= 1'b0;
         pend_rd_r <= 1'b0;
      end else if (dwr_go | drd_go) begin
         pend_step_r <= 1'b1;
         pend_shift_r <= dwr_go & mode_r.shift_en & ~mode_r.cg_sel;
         pend_rd_r <= drd_go;
      end else if (busy_end) begin
         pend_step_r <= 1'b0;
         pend_shift_r <= 1'b0;
         pend_rd_r <= 1'b0;
      end
   end

   // The read latch is refilled only after an address set, a cursor shift or a read,
   // so the first read after a write returns stale data.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         refresh_r <= 1'b0;
      end else begin
         refresh_r <= (cmd_go & (is_cgset | is_ddset | (is_shift & ~byte_w[B_SHIFT_DISP])))
                      | (busy_end & pend_rd_r);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         latch_r <= 8'h00;
      end else if (refresh_r) begin
         latch_r <= mode_r.cg_sel ? cg_mem[addr_counter_r[CG_AW-1:0]]
                                  : dd_mem[addr_counter_r[DD_AW-1:0]];
      end
   end

   // Clear walks all cells at one per cycle, well inside its busy time
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         fill_act_r <= 1'b0;
         fill_cnt_r <= '0;
      end else if (cmd_go && is_clear) begin
         fill_act_r <= 1'b1;
         fill_cnt_r <= '0;
      end else if (fill_act_r) begin
         fill_cnt_r <= DD_AW'(fill_cnt_r + 1'b1);
         fill_act_r <= fill_cnt_r != DD_AW'(DD_DEPTH - 1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (fill_act_r) begin
         dd_mem[fill_cnt_r] <= SPACE_CODE;
      end else if (dwr_go && !mode_r.cg_sel) begin
         dd_mem[addr_counter_r[DD_AW-1:0]] <= byte_w;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (dwr_go && mode_r.cg_sel) begin
         cg_mem[addr_counter_r[CG_AW-1:0]] <= byte_w;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !mode_r.blink_on) begin
         blink_cnt_r <= '0;
         blink_ph_r <= 1'b0;
      end else if (blink_cnt_r == BLINK_W'(BLINK_CYC - 1)) begin
         blink_cnt_r <= '0;
         blink_ph_r <= ~blink_ph_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + BLINK_W'(1);
      end
   end

   // Display off blanks cursor and blink too; RAM is never touched here
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         panel <= '0;
      end else begin
         panel.disp_on <= mode_r.disp_on;
         panel.cursor_row8 <= mode_r.disp_on & mode_r.cursor_on & ~mode_r.font_big;
         panel.cursor_row11 <= mode_r.disp_on & mode_r.cursor_on & mode_r.font_big;
         panel.blink_fill <= mode_r.disp_on & mode_r.blink_on & blink_ph_r;
         panel.shift_offset <= shift_off_r;
         panel.cursor_addr <= addr_counter_r;
      end
   end

   sequence s_data_op;
      dwr_go || drd_go;
   endsequence

   a_clear_exec: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cmd_go && is_clear |=> busy_cnt_r == BUSY_W'(CLEAR_CYC) && addr_counter_r == 7'h00 &&
      fill_act_r)
      else $error("clear did not start fill and busy");
   a_clear_incr: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cmd_go && is_clear |=> mode_r.entry_inc)
      else $error("clear left direction decrementing");
   a_home_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cmd_go && is_home |=> addr_counter_r == 7'h00 && shift_off_r == 7'h00 && !fill_act_r)
      else $error("return home wrong");
   a_entry_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cmd_go && is_entry |=> mode_r.entry_inc == $past(byte_w[1]) &&
      mode_r.shift_en == $past(byte_w[0]) && busy_cnt_r == BUSY_W'(CMD_CYC))
      else $error("entry mode not stored");
   a_step_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pend_step_r && busy_cnt_r > BUSY_W'(1) && !cmd_go |=> $stable(addr_counter_r))
      else $error("address moved before busy dropped");
   a_step_dir: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pend_step_r && busy_end |=>
      addr_counter_r == clid_step($past(addr_counter_r), mode_r.entry_inc, mode_r.cg_sel) &&
      !busy_bit)
      else $error("address step wrong");
   a_no_rd_shift: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_data_op ##0 (drd_go || mode_r.cg_sel) |=> !pend_shift_r)
      else $error("shift armed on read or pattern access");
   a_disp_ctl: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cmd_go && is_dctl |=> ##1 panel.disp_on == $past(byte_w[2], 2) &&
      mode_r.cursor_on == $past(byte_w[1], 2))
      else $error("display control not applied");
   a_status_rd: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cmd_rd && mode_r.bus_width |=> hrdata[7:0] == {$past(busy_bit), $past(addr_counter_r)})
      else $error("status read wrong");
   a_cursor_row: assert property (@(posedge sys_clk) disable iff (!rst_n)
      mode_r.disp_on && mode_r.cursor_on && !mode_r.font_big ##1 $stable(mode_r) |->
      panel.cursor_row8)
      else $error("cursor row not drawn");
   a_blink_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
      mode_r.blink_on && blink_cnt_r == BLINK_W'(BLINK_CYC - 1) && $stable(mode_r.blink_on)
      |=> blink_ph_r != $past(blink_ph_r))
      else $error("blink phase did not toggle");
   a_data_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_data_op |=> busy_cnt_r == BUSY_W'(DATA_CYC) && pend_step_r)
      else $error("data access busy time wrong");
endmodule // clid_top

// ==== core/clid_pkg.sv ====
// Constants, field layouts and carrier types of the character display instruction decoder
package clid_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_CLEAR_NS = 1530000;
   localparam int T_CMD_NS = 39000;
   localparam int T_DATA_NS = 43000;
   localparam int T_BLINK_MS = 400;
   localparam int CLEAR_CYC_DEF = (T_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CMD_CYC = (T_CMD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_CYC = (T_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLINK_CYC_DEF = (T_BLINK_MS * 1000000) / CLK_PERIOD_NS;
   localparam int BUSY_W = 17;
   localparam int BLINK_W = 25;
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [7:0] CLEAR_CODE = 8'h01;
   localparam logic RST_ENTRY_INC = 1'b1;
   localparam logic RST_SHIFT_EN = 1'b0;
   localparam logic RST_DISP_ON = 1'b0;
   localparam logic RST_CURSOR_ON = 1'b0;
   localparam logic RST_BLINK_ON = 1'b0;
   localparam logic RST_BUS_WIDTH = 1'b1;
   localparam logic RST_TWO_LINE = 1'b0;
   localparam logic RST_FONT_BIG = 1'b0;
   localparam logic RST_CG_SEL = 1'b0;
   // Field positions inside the command byte
   localparam int B_INC = 1;
   localparam int B_AUTO_SHIFT = 0;
   localparam int B_DISP = 2;
   localparam int B_CUR = 1;
   localparam int B_BLINK = 0;
   localparam int B_SHIFT_DISP = 3;
   localparam int B_SHIFT_RIGHT = 2;
   localparam int B_BUS_WIDTH = 4;
   localparam int B_TWO_LINE = 3;
   localparam int B_FONT_BIG = 2;

   typedef struct packed {
      logic entry_inc;
      logic shift_en;
      logic disp_on;
      logic cursor_on;
      logic blink_on;
      logic bus_width;
      logic two_line;
      logic font_big;
      logic cg_sel;
   } clid_mode_type;

   typedef struct packed {
      logic disp_on;
      logic cursor_row8;
      logic cursor_row11;
      logic blink_fill;
      logic [6:0] shift_offset;
      logic [6:0] cursor_addr;
   } clid_panel_type;
endpackage

// ==== tb/clid_host_model.sv ====
// Host processor model: single AHB-Lite word transfers and busy polling
`timescale 1ns/100ps
module clid_host_model (
   input wire logic sys_clk,
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic [31:0] rd_val,
   output logic rd_tgl
);
   import clid_pkg::*;
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
      rd_val = 32'h0;
      rd_tgl = 1'b0;
   end
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic chk, output logic [31:0] r);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1);
      r = hrdata;
      // Released lines show no leftover value
      hwdata <= ~d;
      haddr <= ~a;
      if (!w && chk) begin
         rd_val <= hrdata;
         rd_tgl <= ~rd_tgl;
      end
   endtask
   // Polls the status word until the busy bit drops, bounded
   task automatic wait_idle();
      logic [31:0] s;
      int n;
      s = 32'h80;
      n = 0;
      while (s[7] !== 1'b0 && n < 4000) begin
         xfer(OFS_CMD, 1'b0, 32'h0, 1'b0, s);
         n++;
      end
   endtask
endmodule // clid_host_model

// ==== tb/clid_tb_top.sv ====
// Self-checking bench of the instruction decoder, driven through the host model
`timescale 1ns/100ps
module clid_tb_top;
   import clid_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, rd_tgl;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd_val, seed, r;
   logic [7:0] a, b;
   logic prev;
   clid_panel_type panel;
   logic [31:0] q[$];
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   // Small clear and blink counts keep the run short
   clid_top #(.CLEAR_CYC(200), .BLINK_CYC(16)) i_clid_top (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .panel(panel));
   clid_host_model i_clid_host_model (
      .sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .rd_val(rd_val), .rd_tgl(rd_tgl));
   always #12.5 sys_clk = ~sys_clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("Totals: %0d checks, %0d mismatches", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic put(input logic [7:0] ad, input logic [7:0] d);
      i_clid_host_model.xfer(ad, 1'b1, {24'h0, d}, 1'b0, r);
   endtask
   task automatic idle();
      i_clid_host_model.wait_idle();
   endtask
   task automatic cmd(input logic [7:0] d);
      put(OFS_CMD, d);
      idle();
   endtask
   task automatic dwr(input logic [7:0] d);
      put(OFS_DATA, d);
      idle();
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
      q.push_back(exp);
      i_clid_host_model.xfer(ad, 1'b0, 32'h0, 1'b1, r);
   endtask
   task automatic tdone(input string s);
      $display("Test %s finished at %0t ns", s, $time);
   endtask
   // Each read result is matched against the oldest note
   always @(rd_tgl) begin
      if (q.size() != 0) begin
         chk(rd_val, q.pop_front());
      end
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      seed = xs(32'h10C6D913);
      a = {3'b000, seed[4:0]};
      b = seed[15:8];
      rd(OFS_CMD, 32'h0);
      rd(OFS_MODE, 32'h108);
      rd(8'h0C, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      tdone("reset");
      put(OFS_CMD, 8'h01);
      rd(OFS_CMD, 32'h80);
      idle();
      rd(OFS_CMD, 32'h0);
      cmd(8'h85);
      rd(OFS_DATA, 32'h20);
      idle();
      rd(OFS_CMD, 32'h06);
      tdone("clear");
      cmd(8'h80 | a);
      put(OFS_DATA, b);
      rd(OFS_CMD, {24'h0, 8'h80 | a});
      idle();
      rd(OFS_CMD, {24'h0, a + 8'h01});
      cmd(8'h80 | a);
      rd(OFS_DATA, {24'h0, b});
      idle();
      rd(OFS_CMD, {24'h0, a + 8'h01});
      tdone("data");
      // Second command lands while busy and must be dropped
      put(OFS_CMD, 8'h0F);
      put(OFS_CMD, 8'h08);
      idle();
      rd(OFS_MODE, 32'h178);
      chk({29'h0, panel.disp_on, panel.cursor_row8, panel.cursor_row11}, 32'h6);
      n = 0;
      prev = panel.blink_fill;
      repeat (40) begin
         @(posedge sys_clk);
         #1;
         if (panel.blink_fill !== prev) n++;
         prev = panel.blink_fill;
      end
      chk({31'h0, n >= 2}, 32'h1);
      cmd(8'h08);
      chk({31'h0, panel.disp_on}, 32'h0);
      cmd(8'h0C);
      rd(OFS_MODE, 32'h148);
      cmd(8'h80 | a);
      rd(OFS_DATA, {24'h0, b});
      idle();
      tdone("display");
      cmd(8'h04);
      rd(OFS_MODE, 32'h048);
      cmd(8'hA0);
      dwr(seed[23:16]);
      rd(OFS_CMD, 32'h1F);
      cmd(8'h07);
      cmd(8'hB0);
      dwr(b);
      rd(OFS_MODE, 32'h3C8);
      cmd(8'hB0);
      rd(OFS_DATA, {24'h0, b});
      idle();
      rd(OFS_MODE, 32'h3C8);
      cmd(8'h05);
      dwr(b);
      chk({25'h0, panel.shift_offset}, 32'h0);
      // No refresh since the write: the latch still holds the old cell
      rd(OFS_DATA, 32'h20);
      idle();
      tdone("entry");
      cmd(8'h90);
      cmd(8'h14);
      rd(OFS_CMD, 32'h11);
      cmd(8'h10);
      rd(OFS_CMD, 32'h10);
      cmd(8'h1C);
      chk({25'h0, panel.shift_offset}, 32'h7F);
      rd(OFS_CMD, 32'h10);
      chk({25'h0, panel.cursor_addr}, 32'h10);
      cmd(8'h03);
      rd(OFS_CMD, 32'h0);
      chk({25'h0, panel.shift_offset}, 32'h0);
      cmd(8'h80 | a);
      rd(OFS_DATA, {24'h0, b});
      idle();
      tdone("shift");
      cmd(8'h01);
      rd(OFS_MODE, 32'h1C8);
      // Auto shift stays on so pattern RAM writes really test its absence
      cmd(8'h07);
      cmd(8'h3C);
      rd(OFS_MODE, 32'h1CE);
      cmd(8'h30);
      cmd(8'h7F);
      rd(OFS_MODE, 32'h1C9);
      dwr(b);
      rd(OFS_CMD, 32'h0);
      rd(OFS_MODE, 32'h1C9);
      cmd(8'h7F);
      rd(OFS_DATA, {24'h0, b});
      idle();
      put(OFS_CMD, 8'h00);
      rd(OFS_CMD, 32'h0);
      tdone("pattern");
      // Narrow bus: polling would split nibble pairs, so waits are fixed
      put(OFS_CMD, 8'h20);
      repeat (1600) @(posedge sys_clk);
      put(OFS_CMD, 8'h80);
      put(OFS_CMD, 8'h50);
      repeat (1600) @(posedge sys_clk);
      rd(OFS_CMD, 32'h00);
      rd(OFS_CMD, 32'h50);
      rd(OFS_DATA, 32'h20);
      rd(OFS_DATA, 32'h00);
      repeat (1800) @(posedge sys_clk);
      put(OFS_CMD, 8'h30);
      put(OFS_CMD, 8'h00);
      repeat (1600) @(posedge sys_clk);
      rd(OFS_CMD, 32'h06);
      rd(OFS_MODE, 32'h1C8);
      repeat (4) @(posedge sys_clk);
      tdone("narrow");
      conclude();
   end
endmodule // clid_tb_top
